// ### hdl/lcdctl_consts.vh
/*
  Constants for the LCD source-driver control register bank: register
  indices, field positions, reset values and gate/scan constants.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef LCDCTL_CONSTS_VH
`define LCDCTL_CONSTS_VH

// Register indices on the 8-bit index bus
`define LCDCTL_IDX_DISP_CTL1    8'h00
`define LCDCTL_IDX_DISP_CTL2    8'h01
`define LCDCTL_IDX_VIDEO_CTL    8'h02
`define LCDCTL_IDX_CMD_RESET    8'h03
`define LCDCTL_IDX_RAM_ACCESS   8'h05
`define LCDCTL_IDX_COL_START    8'h06
`define LCDCTL_IDX_ROW_START    8'h07
`define LCDCTL_IDX_WIN_COL_LO   8'h08
`define LCDCTL_IDX_WIN_COL_HI   8'h09
`define LCDCTL_IDX_WIN_ROW_LO   8'h0a
`define LCDCTL_IDX_WIN_ROW_HI   8'h0b
`define LCDCTL_IDX_PANEL_SIZE   8'h0d
`define LCDCTL_IDX_SCAN_MODE    8'h1d
`define LCDCTL_IDX_GATE_RESET   8'h22
`define LCDCTL_IDX_MAKER_VER    8'h31
`define LCDCTL_IDX_PART_ID      8'h32
`define LCDCTL_IDX_BLANK_SEL    8'h76

// Reset values
`define LCDCTL_RST_DISP_CTL1    8'ha0
`define LCDCTL_RST_ZERO         8'h00
`define LCDCTL_RST_SCAN_MODE    3'h7

// Field positions
`define LCDCTL_B_SRC_SEL_HI     7
`define LCDCTL_B_SRC_SEL_LO     6
`define LCDCTL_B_SRC_DIR        5
`define LCDCTL_B_PARTIAL        4
`define LCDCTL_B_COLOR8         2
`define LCDCTL_B_PARTIAL_SCAN   0
`define LCDCTL_B_COL_DIR        7
`define LCDCTL_B_ROW_DIR        6
`define LCDCTL_B_WIN_ONLY       3
`define LCDCTL_B_CAPTURE        2
`define LCDCTL_B_TIMING         1
`define LCDCTL_B_VID_WR         0
`define LCDCTL_B_FAST_WR        6
`define LCDCTL_B_WIN_EN         4
`define LCDCTL_B_ROW_INC        2
`define LCDCTL_B_BIT0           0

// Gate output numbering, scan constants and RAM address limits
`define LCDCTL_GATE_LAST        8'd241
`define LCDCTL_LINES_220        8'd220
`define LCDCTL_LINES_240        8'd240
`define LCDCTL_BLANK_LINES      8'd7
`define LCDCTL_COL_MAX          8'haf
`define LCDCTL_ROW_MAX          8'hef
`define LCDCTL_GATE_LINK_BITS   16

`endif

// ### hdl/lcdctl_regs.v
/*
  Control register bank of an LCD source driver with display RAM:
  host-written control registers, RAM write address generation with
  window wrap, gate scan sequencing for 220/240-line panels, a serial
  relay of the gate-driver reset, and identification registers.
  Assumes a synchronous host index/data port clocked by i_clk and a
  companion gate driver that samples o_gate_sclk/o_gate_sdat.
*/
`timescale 1ns/1ps
`include "lcdctl_consts.vh"

module lcdctl_regs #(
  parameter [3:0] MAKER_CODE   = 4'h5,   // Arbitrary neutral value
  parameter [3:0] VERSION_CODE = 4'h3,   // Arbitrary neutral value
  parameter [7:0] PART_CODE    = 8'h5a   // Arbitrary neutral value
) (
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_wr,                // Register write strobe
  input  wire       i_rd,                // Register read strobe
  input  wire [7:0] i_idx,               // Register index
  input  wire [7:0] i_wdata,             // Write data
  input  wire       i_ram_wr,            // One RAM data word written
  input  wire       i_line_step,         // Advance one gate scan slot
  input  wire       i_dummy_position_pin,// High: dummy before frame
  output reg  [7:0] o_rdata,             // Read data
  output wire       o_source_data_sel_hi,
  output wire       o_source_data_sel_lo,
  output wire       o_source_reversed,   // Y528 side gets RAM 00H
  output wire       o_partial_display_en,
  output wire       o_color8,
  output wire       o_partial_off_scan_sel,
  output wire       o_column_dir,
  output wire       o_row_dir,
  output wire       o_video_window_only,
  output wire       o_display_timing_sel,
  output wire       o_video_ram_write_en,
  output wire       o_fast_write_mode,
  output wire       o_row_increment,
  output wire       o_window_access_en,
  output reg  [7:0] o_ram_col,           // Current RAM column address
  output reg  [7:0] o_ram_row,           // Current RAM row address
  output reg  [7:0] o_gate_out,          // Active gate output, 0 = none
  output reg        o_gate_dummy,        // Current slot is dummy line
  output reg        o_gate_blank,        // Current slot is blanking
  output reg        o_gate_sclk,         // Serial link clock to gate
  output reg        o_gate_sdat,         // Serial link data to gate
  output reg        o_gate_sbusy         // Serial link transfer running
);

  // Scan mode codes, SCN field values
  localparam [2:0] SCAN_STRAIGHT = 3'b111;
  localparam [2:0] SCAN_FOLD121  = 3'b011;
  localparam [2:0] SCAN_FOLD161  = 3'b101;
  localparam [2:0] SCAN_FOLD201  = 3'b001;

  // Reset synchroniser
  reg        rst_meta;
  reg        rst_n;

  // Register state
  reg  [7:0] disp_ctl1;
  reg  [7:0] disp_ctl2;
  reg  [7:0] video_ctl;
  reg        command_reset_bit;
  reg  [7:0] ram_access;
  reg  [7:0] column_start;
  reg  [7:0] row_start;
  reg  [7:0] window_col_begin;
  reg  [7:0] window_col_end;
  reg  [7:0] window_row_begin;
  reg  [7:0] window_row_end;
  reg        panel_220;
  reg  [2:0] scan_mode;
  reg        scan_left;             // Gate driver mounted left-hand
  reg        blanking_select;

  // Scan sequencer
  reg  [7:0] slot;                  // Slot within the frame sequence
  reg  [7:0] next_slot;

  // Serial relay
  reg  [4:0] ser_cnt;
  reg [15:0] ser_shift;

  wire       soft_reset;
  wire       video_on;
  wire [7:0] lines;
  wire       blank_on;
  wire [7:0] frame_len;

  // Release the asynchronous reset through two flops
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // A pending command reset wipes the bank on the next register write or RAM word
  assign soft_reset = command_reset_bit & (i_wr | i_ram_wr);
  assign video_on   = video_ctl[`LCDCTL_B_VID_WR];

  // Host register writes
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_ctl1         <= `LCDCTL_RST_DISP_CTL1;
      disp_ctl2         <= `LCDCTL_RST_ZERO;
      video_ctl         <= `LCDCTL_RST_ZERO;
      command_reset_bit <= 1'b0;
      ram_access        <= `LCDCTL_RST_ZERO;
      column_start      <= `LCDCTL_RST_ZERO;
      row_start         <= `LCDCTL_RST_ZERO;
      window_col_begin  <= `LCDCTL_RST_ZERO;
      window_col_end    <= `LCDCTL_RST_ZERO;
      window_row_begin  <= `LCDCTL_RST_ZERO;
      window_row_end    <= `LCDCTL_RST_ZERO;
      panel_220         <= 1'b0;
      scan_mode         <= `LCDCTL_RST_SCAN_MODE;
      scan_left         <= 1'b0;
      blanking_select   <= 1'b0;
    end else if (soft_reset) begin
      // Whole bank back to defaults, the triggering access is dropped
      disp_ctl1         <= `LCDCTL_RST_DISP_CTL1;
      disp_ctl2         <= `LCDCTL_RST_ZERO;
      video_ctl         <= `LCDCTL_RST_ZERO;
      command_reset_bit <= 1'b0;
      ram_access        <= `LCDCTL_RST_ZERO;
      column_start      <= `LCDCTL_RST_ZERO;
      row_start         <= `LCDCTL_RST_ZERO;
      window_col_begin  <= `LCDCTL_RST_ZERO;
      window_col_end    <= `LCDCTL_RST_ZERO;
      window_row_begin  <= `LCDCTL_RST_ZERO;
      window_row_end    <= `LCDCTL_RST_ZERO;
      panel_220         <= 1'b0;
      scan_mode         <= `LCDCTL_RST_SCAN_MODE;
      scan_left         <= 1'b0;
      blanking_select   <= 1'b0;
    end else if (i_wr) begin
      case (i_idx)
        `LCDCTL_IDX_DISP_CTL1:  disp_ctl1 <= i_wdata;
        `LCDCTL_IDX_DISP_CTL2:  disp_ctl2 <= i_wdata;
        // Capture-mode bit is held at 0, the other value is prohibited
        `LCDCTL_IDX_VIDEO_CTL:  video_ctl <= i_wdata & 8'hfb;
        `LCDCTL_IDX_CMD_RESET:  command_reset_bit <= i_wdata[`LCDCTL_B_BIT0];
        `LCDCTL_IDX_RAM_ACCESS: ram_access <= i_wdata;
        `LCDCTL_IDX_COL_START:  column_start <= i_wdata;
        `LCDCTL_IDX_ROW_START:  row_start <= i_wdata;
        `LCDCTL_IDX_WIN_COL_LO: window_col_begin <= i_wdata;
        `LCDCTL_IDX_WIN_COL_HI: window_col_end <= i_wdata;
        `LCDCTL_IDX_WIN_ROW_LO: window_row_begin <= i_wdata;
        `LCDCTL_IDX_WIN_ROW_HI: window_row_end <= i_wdata;
        `LCDCTL_IDX_PANEL_SIZE: panel_220 <= i_wdata[`LCDCTL_B_BIT0];
        `LCDCTL_IDX_SCAN_MODE: begin
          scan_mode <= i_wdata[2:0];
          scan_left <= i_wdata[7];
        end
        `LCDCTL_IDX_BLANK_SEL:  blanking_select <= i_wdata[`LCDCTL_B_BIT0];
        default: ;              // Unmapped or read-only: write ignored
      endcase
    end
  end

  // Control fields to the display datapath
  assign o_source_data_sel_hi   = disp_ctl1[`LCDCTL_B_SRC_SEL_HI];
  assign o_source_data_sel_lo   = disp_ctl1[`LCDCTL_B_SRC_SEL_LO];
  assign o_source_reversed      = disp_ctl1[`LCDCTL_B_SRC_DIR];
  assign o_partial_display_en   = disp_ctl1[`LCDCTL_B_PARTIAL];
  assign o_color8               = disp_ctl1[`LCDCTL_B_COLOR8];
  assign o_partial_off_scan_sel = disp_ctl1[`LCDCTL_B_PARTIAL_SCAN];
  // Direction bits read as 0 while the video port writes RAM
  assign o_column_dir = disp_ctl2[`LCDCTL_B_COL_DIR] & ~video_on;
  assign o_row_dir    = disp_ctl2[`LCDCTL_B_ROW_DIR] & ~video_on;
  assign o_video_window_only  = video_ctl[`LCDCTL_B_WIN_ONLY];
  assign o_display_timing_sel = video_ctl[`LCDCTL_B_TIMING];
  assign o_video_ram_write_en = video_on;
  assign o_fast_write_mode    = ram_access[`LCDCTL_B_FAST_WR];
  // Row increment is the host's duty to avoid; passed through as set
  assign o_row_increment      = ram_access[`LCDCTL_B_ROW_INC];
  assign o_window_access_en   = ram_access[`LCDCTL_B_WIN_EN] | video_on;

  // RAM address counter with window wrap
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ram_col <= 8'h00;
      o_ram_row <= 8'h00;
    end else if (soft_reset) begin
      o_ram_col <= 8'h00;
      o_ram_row <= 8'h00;
    end else if (i_wr && !video_on && i_idx == `LCDCTL_IDX_COL_START) begin
      o_ram_col <= i_wdata;
    end else if (i_wr && !video_on && i_idx == `LCDCTL_IDX_ROW_START) begin
      o_ram_row <= i_wdata;
    end else if (i_wr && i_wdata[`LCDCTL_B_VID_WR] && i_idx == `LCDCTL_IDX_VIDEO_CTL) begin
      // Video frames start at the window origin; start registers unused
      o_ram_col <= window_col_begin;
      o_ram_row <= window_row_begin;
    end else if (i_ram_wr) begin
      if (o_window_access_en && o_ram_col == window_col_end) begin
        o_ram_col <= window_col_begin;
        if (o_ram_row == window_row_end)
          o_ram_row <= window_row_begin;
        else
          o_ram_row <= o_ram_row + 8'h01;
      end else if (!o_window_access_en && o_ram_col == `LCDCTL_COL_MAX) begin
        o_ram_col <= 8'h00;
        o_ram_row <= (o_ram_row == `LCDCTL_ROW_MAX) ? 8'h00 : o_ram_row + 8'h01;
      end else begin
        o_ram_col <= o_ram_col + 8'h01;
      end
    end
  end

  // Blanking only counts under internal timing
  assign blank_on  = blanking_select & ~o_display_timing_sel;
  assign lines     = panel_220 ? `LCDCTL_LINES_220 : `LCDCTL_LINES_240;
  // Frame = data lines + one dummy + optional seven blank slots
  assign frame_len = lines + 8'd1 + (blank_on ? `LCDCTL_BLANK_LINES : 8'd0);

  // Map a scan position (0 = first data line) to a gate output number
  function [7:0] gate_map;
    input [7:0] pos;
    input [2:0] mode;
    input       left;
    input       p220;
    reg   [7:0] fold;
    reg   [7:0] half;
    reg   [7:0] base;
    begin
      fold = 8'd0;
      half = 8'd0;
      base = p220 ? 8'd21 : 8'd1;
      case (mode)
        SCAN_FOLD121: fold = 8'd121;
        SCAN_FOLD161: fold = p220 ? 8'd141 : 8'd161;
        SCAN_FOLD201: fold = p220 ? 8'd181 : 8'd201;
        default:      fold = 8'd0;
      endcase
      if (!mode[0]) begin
        // Interleave, alternating between the two halves
        half = pos >> 1;
        if (!left)
          gate_map = pos[0] ? `LCDCTL_GATE_LAST - half : half + 8'd1;
        else if (p220)
          gate_map = pos[0] ? 8'd122 + half : 8'd121 - half;
        else
          gate_map = pos[0] ? 8'd122 + half : 8'd121 - half;
      end else if (mode == SCAN_STRAIGHT) begin
        if (!left)
          gate_map = pos + 8'd1;
        else
          gate_map = `LCDCTL_GATE_LAST - pos;
      end else if (!left) begin
        // Up to the fold, then back down from the top, reserve skipped
        gate_map = (pos < fold) ? pos + 8'd1
                                : `LCDCTL_GATE_LAST - (pos - fold);
      end else begin
        // Left fold starts past the reserved block, then folds down
        if (pos < `LCDCTL_GATE_LAST - fold - (p220 ? 8'd20 : 8'd0))
          gate_map = fold + (p220 ? 8'd21 : 8'd1) + pos;
        else
          gate_map = fold - (pos - (`LCDCTL_GATE_LAST - fold
                     - (p220 ? 8'd20 : 8'd0)));
        if (mode == SCAN_FOLD121)
          gate_map = (pos < 8'd120) ? 8'd122 + pos : 8'd121 - (pos - 8'd120);
      end
      if (gate_map < base && left && mode != SCAN_FOLD161 && mode[0])
        gate_map = 8'd0;
    end
  endfunction

  // Dummy output: the slot that follows the last data line
  function [7:0] dummy_map;
    input [7:0] nlines;
    input [2:0] mode;
    input       left;
    input       p220;
    begin
      dummy_map = gate_map(nlines, mode, left, p220);
      if (mode == SCAN_FOLD161 && left && p220)
        dummy_map = 8'd1;
      else if (!mode[0] && left && p220)
        dummy_map = 8'd11;
      else if (!mode[0] && !left && p220)
        dummy_map = 8'd111;
    end
  endfunction

  // Gate scan sequencer, one slot per i_line_step
  always @* begin
    next_slot = slot;
    if (i_line_step)
      next_slot = (slot >= frame_len - 8'd1) ? 8'd0 : slot + 8'd1;
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot         <= 8'd0;
      o_gate_out   <= 8'd0;
      o_gate_dummy <= 1'b0;
      o_gate_blank <= 1'b0;
    end else begin
      slot <= next_slot;
      if (!i_dummy_position_pin) begin
        // Frame data first, then dummy, then any blanking
        o_gate_blank <= next_slot > lines;
        o_gate_dummy <= next_slot == lines;
        if (next_slot < lines)
          o_gate_out <= gate_map(next_slot, scan_mode, scan_left, panel_220);
        else if (next_slot == lines)
          o_gate_out <= dummy_map(lines, scan_mode, scan_left, panel_220);
        else
          o_gate_out <= 8'd0;
      end else begin
        // Blanking, then dummy; the order shifts so the dummy takes its first output
        o_gate_blank <= next_slot < frame_len - lines - 8'd1;
        o_gate_dummy <= next_slot == frame_len - lines - 8'd1;
        if (next_slot < frame_len - lines - 8'd1)
          o_gate_out <= 8'd0;
        else if (next_slot < frame_len - 8'd1)
          o_gate_out <= gate_map(next_slot - (frame_len - lines - 8'd1), scan_mode,
                                 scan_left, panel_220);
        else
          o_gate_out <= dummy_map(lines, scan_mode, scan_left, panel_220);
      end
    end
  end

  // Serial relay of the gate-driver reset: 8-bit index then 8-bit data,
  // MSB first, one bit per two clocks. Gate-reset writes during a transfer are lost.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_cnt      <= 5'd0;
      ser_shift    <= 16'h0000;
      o_gate_sclk  <= 1'b0;
      o_gate_sdat  <= 1'b0;
      o_gate_sbusy <= 1'b0;
    end else if (!o_gate_sbusy) begin
      o_gate_sclk <= 1'b0;
      if (i_wr && i_idx == `LCDCTL_IDX_GATE_RESET && i_wdata[`LCDCTL_B_BIT0]) begin
        ser_shift    <= {`LCDCTL_IDX_GATE_RESET, 8'h01};
        ser_cnt      <= 5'd16;
        o_gate_sbusy <= 1'b1;
      end
    end else if (!o_gate_sclk) begin
      o_gate_sdat <= ser_shift[15];
      o_gate_sclk <= 1'b1;
    end else begin
      o_gate_sclk <= 1'b0;
      ser_shift   <= {ser_shift[14:0], 1'b0};
      ser_cnt     <= ser_cnt - 5'd1;
      if (ser_cnt == 5'd1)
        o_gate_sbusy <= 1'b0;
    end
  end

  // Read data, registered; write-only registers read zero
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_idx)
        `LCDCTL_IDX_MAKER_VER: o_rdata <= {MAKER_CODE, VERSION_CODE};
        `LCDCTL_IDX_PART_ID:   o_rdata <= PART_CODE;
        default:               o_rdata <= 8'h00;
      endcase
    end
  end

endmodule // lcdctl_regs

// ### dv/lcdctl_regs_chk.sv
/* Checker for the lcdctl_regs control register bank.
   Assumes it is bound into lcdctl_regs with the same identity parameters. */
`timescale 1ns/1ps
module lcdctl_regs_chk #(
  parameter [3:0] MAKER_CODE   = 4'h5,   // Arbitrary neutral value
  parameter [3:0] VERSION_CODE = 4'h3,   // Arbitrary neutral value
  parameter [7:0] PART_CODE    = 8'h5a   // Arbitrary neutral value
) (
  input logic       i_clk,
  input logic       i_arst_n,
  input logic       i_wr,
  input logic       i_rd,
  input logic [7:0] i_idx,
  input logic [7:0] i_wdata,
  input logic       i_ram_wr,
  input logic [7:0] o_rdata,
  input logic       o_partial_display_en,
  input logic       o_color8,
  input logic       o_column_dir,
  input logic       o_row_dir,
  input logic       o_video_ram_write_en,
  input logic       o_window_access_en,
  input logic       o_row_increment,
  input logic [7:0] o_ram_col,
  input logic       o_gate_sbusy
);
  logic       cmd_pend;  // Command reset armed: next write or RAM access is swallowed
  logic [7:0] win_lo;    // Shadow of the column window begin
  logic [7:0] win_hi;    // Shadow of the column window end
  wire        wr_ok = i_wr && !cmd_pend;  // Write that really lands
  wire        ram_ok = i_ram_wr && !cmd_pend && !i_wr;  // Plain address step
  // Shadows follow host writes; the swallowed access clears them
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_pend <= 1'b0;
      win_lo   <= 8'h00;
      win_hi   <= 8'h00;
    end else if (cmd_pend && (i_wr || i_ram_wr)) begin
      cmd_pend <= 1'b0;
      win_lo   <= 8'h00;
      win_hi   <= 8'h00;
    end else if (i_wr) begin
      if (i_idx == 8'h03) cmd_pend <= i_wdata[0];
      if (i_idx == 8'h08) win_lo <= i_wdata;
      if (i_idx == 8'h09) win_hi <= i_wdata;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_gate_req;
    wr_ok && i_idx == 8'h22 && i_wdata[0] && !o_gate_sbusy;
  endsequence
  sequence s_gate_run;
    o_gate_sbusy [*8];
  endsequence
  property p_gate_start; s_gate_req |=> s_gate_run; endproperty
  a_gate_start: assert property (p_gate_start) else $error("gate link idle after request");
  property p_gate_len; s_gate_req |=> ##31 o_gate_sbusy ##1 !o_gate_sbusy; endproperty
  a_gate_len: assert property (p_gate_len) else $error("gate link length wrong");
  property p_ctl_one;
    wr_ok && i_idx == 8'h00 |=> o_partial_display_en == $past(i_wdata[4])
      && o_color8 == $past(i_wdata[2]);
  endproperty
  a_ctl_one: assert property (p_ctl_one) else $error("control one fields wrong");
  property p_vid_win; o_video_ram_write_en |-> o_window_access_en; endproperty
  a_vid_win: assert property (p_vid_win) else $error("window not forced on");
  property p_vid_dir; o_video_ram_write_en |-> !o_column_dir && !o_row_dir; endproperty
  a_vid_dir: assert property (p_vid_dir) else $error("direction not cleared");
  property p_id_one; i_rd && i_idx == 8'h31 |=> o_rdata == {MAKER_CODE, VERSION_CODE}; endproperty
  a_id_one: assert property (p_id_one) else $error("maker version read wrong");
  property p_id_two; i_rd && i_idx == 8'h32 |=> o_rdata == PART_CODE; endproperty
  a_id_two: assert property (p_id_two) else $error("part code read wrong");
  property p_rd_hold; !i_rd |=> $stable(o_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_win_wrap;
    ram_ok && !o_row_increment && o_window_access_en && o_ram_col == win_hi
      |=> o_ram_col == $past(win_lo);
  endproperty
  a_win_wrap: assert property (p_win_wrap) else $error("column did not wrap");
endmodule // lcdctl_regs_chk

bind lcdctl_regs lcdctl_regs_chk #(
  .MAKER_CODE(MAKER_CODE),
  .VERSION_CODE(VERSION_CODE),
  .PART_CODE(PART_CODE)
) chk_u (.*);

// ### dv/lcdctl_host.sv
/* Host processor model on the register port of lcdctl_regs.
   Assumes requests are taken at the first rising edge they are seen. */
`timescale 1ns/1ps
module lcdctl_host (
  input  logic       i_clk,
  input  logic [7:0] i_rdata,   // Read data from the device
  output logic       o_wr,      // Register write strobe
  output logic       o_rd,      // Register read strobe
  output logic       o_ram_wr,  // RAM word strobe
  output logic [7:0] o_idx,     // Register index
  output logic [7:0] o_wdata    // Write data
);
  // Idle values; released buses carry scrambled data, never stale values
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_ram_wr = 1'b0;
    o_idx = 8'hff;
    o_wdata = 8'h00;
  end
  // Callers keep column/row within range and never mix row step with fast write
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_idx   <= idx;
    o_wdata <= dat;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_idx   <= ~idx;
    o_wdata <= ~dat;
  endtask
  // Read: data is registered by the taking edge, picked up mid-cycle
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
    @(posedge i_clk);
    o_rd  <= 1'b1;
    o_idx <= idx;
    @(posedge i_clk);
    o_rd  <= 1'b0;
    o_idx <= ~idx;
    @(negedge i_clk);
    dat = i_rdata;
  endtask
  // One RAM word, advancing the write address
  task automatic ram();
    @(posedge i_clk);
    o_ram_wr <= 1'b1;
    @(posedge i_clk);
    o_ram_wr <= 1'b0;
  endtask
endmodule // lcdctl_host

// ### dv/tb_lcdctl_regs.sv
/* Self-checking bench for lcdctl_regs with the host model.
   Assumes a 20 MHz clock and the reset release described for the block. */
`timescale 1ns/1ps
module tb_lcdctl_regs;
  localparam logic [3:0] MK = 4'h9;   // Arbitrary neutral value
  localparam logic [3:0] VR = 4'h6;   // Arbitrary neutral value
  localparam logic [7:0] PC = 8'hc3;  // Arbitrary neutral value
  localparam logic [13:0] RST = 14'b10100000000000;  // Flags after reset
  typedef struct {logic [7:0] idx; logic [7:0] dat; logic [13:0] exp;} lcdctl_row_t;
  typedef struct {logic [7:0] code; logic pin, blank, tim;
                  logic [7:0] dummy, nxt; logic [15:0] len, nb;} lcdctl_scan_t;
  logic i_clk = 1'b0, i_arst_n, i_wr, i_rd, i_ram_wr, i_line_step, i_dummy_position_pin;
  logic [7:0] i_idx, i_wdata;
  wire [7:0] o_rdata, o_ram_col, o_ram_row, o_gate_out;
  wire o_source_data_sel_hi, o_source_data_sel_lo, o_source_reversed, o_partial_display_en;
  wire o_color8, o_partial_off_scan_sel, o_column_dir, o_row_dir, o_video_window_only;
  wire o_display_timing_sel, o_video_ram_write_en, o_fast_write_mode, o_row_increment;
  wire o_window_access_en, o_gate_dummy, o_gate_blank, o_gate_sclk, o_gate_sdat, o_gate_sbusy;
  wire [13:0] flags = {o_source_data_sel_hi, o_source_data_sel_lo, o_source_reversed,
    o_partial_display_en, o_color8, o_partial_off_scan_sel, o_column_dir, o_row_dir,
    o_video_window_only, o_display_timing_sel, o_video_ram_write_en, o_fast_write_mode,
    o_row_increment, o_window_access_en};
  int err_count = 0;        // Mismatches seen
  int samples_checked = 0;  // Comparisons made
  lcdctl_regs #(.MAKER_CODE(MK), .VERSION_CODE(VR), .PART_CODE(PC)) dut_u (.*);
  lcdctl_host host_u (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_ram_wr(i_ram_wr), .o_idx(i_idx), .o_wdata(i_wdata));
  // Free-running 50 ns clock
  always #25 i_clk = ~i_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Runs frames in one scan setup; the first frames after a switch are discarded
  task automatic scan_check(input lcdctl_scan_t s);
    int n, nb, g;
    logic [7:0] nx;
    host_u.wr(8'h1d, s.code);
    host_u.wr(8'h76, {7'h00, s.blank});
    host_u.wr(8'h02, {6'h00, s.tim, 1'b0});
    i_dummy_position_pin <= s.pin;
    i_line_step <= 1'b1;
    repeat (3) begin
      g = 0;
      while (!o_gate_dummy && g < 600) begin
        @(negedge i_clk);
        g++;
      end
      if (g < 600) @(negedge i_clk);
    end
    while (!o_gate_dummy && g < 1200) begin
      @(negedge i_clk);
      g++;
    end
    check(o_gate_out, s.dummy);
    n = 0;
    nb = 0;
    nx = 8'h00;
    do begin
      @(negedge i_clk);
      n++;
      if (o_gate_blank) nb++;
      if (nx == 8'h00 && o_gate_out != 8'h00 && !o_gate_dummy) nx = o_gate_out;
    end while (!o_gate_dummy && n < 600);
    check(nx, s.nxt);
    check(n[15:0], s.len);
    check(nb[15:0], s.nb);
    @(posedge i_clk);
    i_line_step <= 1'b0;
  endtask
  // Watchdog: about two and a half times the expected run
  initial begin
    #(30000 * 50);
    err_count++;
    give_verdict();
  end
  initial begin
    lcdctl_row_t rows [10] = '{'{8'h00, 8'h14, 14'b00011000000000},
      '{8'h00, 8'he5, 14'b11101100000000}, '{8'h01, 8'hc0, 14'b11101111000000},
      '{8'h02, 8'h0e, 14'b11101111110000}, '{8'h05, 8'h14, 14'b11101111110011},
      '{8'h05, 8'h40, 14'b11101111110100}, '{8'h02, 8'h01, 14'b11101100001101},
      '{8'h31, 8'hff, 14'b11101100001101}, '{8'h04, 8'hff, 14'b11101100001101},
      '{8'h02, 8'h00, 14'b11101111000100}};
    lcdctl_scan_t scans [11] = '{'{8'h07, 0, 0, 0, 221, 1, 221, 0},
      '{8'h07, 1, 0, 0, 1, 2, 221, 0}, '{8'h87, 0, 0, 0, 21, 241, 221, 0},
      '{8'h03, 0, 0, 0, 142, 1, 221, 0}, '{8'h05, 0, 0, 0, 162, 1, 221, 0},
      '{8'h85, 0, 0, 0, 1, 162, 221, 0}, '{8'h00, 0, 0, 0, 111, 1, 221, 0},
      '{8'h80, 0, 0, 0, 11, 121, 221, 0}, '{8'h07, 0, 1, 0, 221, 1, 228, 7},
      '{8'h07, 0, 1, 1, 221, 1, 221, 0}, '{8'h80, 1, 0, 0, 121, 122, 221, 0}};
    logic [7:0] rdv;
    logic [15:0] sh;
    int nbusy;
    logic prev;
    i_arst_n = 1'b0;
    i_line_step = 1'b0;
    i_dummy_position_pin = 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check(flags, RST);
    foreach (rows[k]) begin
      host_u.wr(rows[k].idx, rows[k].dat);
      @(negedge i_clk);
      check(flags, rows[k].exp);
    end
    $display("register table done");
    host_u.rd(8'h31, rdv);
    check(rdv, {MK, VR});
    host_u.rd(8'h32, rdv);
    check(rdv, PC);
    host_u.rd(8'h04, rdv);
    check(rdv, 8'h00);
    $display("identification done");
    host_u.wr(8'h06, 8'hae);
    host_u.wr(8'h07, 8'hee);
    host_u.ram();
    host_u.ram();
    @(negedge i_clk);
    check({o_ram_row, o_ram_col}, 16'hef00);
    foreach (rows[k]) if (k < 4) host_u.wr(8'h08 + k[7:0], 8'h10 + {2'b00, k[2:1], 3'h0, k[0]});
    host_u.wr(8'h05, 8'h10);
    host_u.wr(8'h06, 8'h10);
    host_u.wr(8'h07, 8'h21);
    host_u.ram();
    host_u.ram();
    @(negedge i_clk);
    check({o_ram_row, o_ram_col}, 16'h2010);
    host_u.wr(8'h02, 8'h01);
    host_u.wr(8'h06, 8'h55);
    @(negedge i_clk);
    check({o_ram_row, o_ram_col}, 16'h2010);
    host_u.wr(8'h02, 8'h00);
    $display("address generation done");
    host_u.wr(8'h22, 8'h01);
    sh = 16'h0000;
    nbusy = 0;
    prev = 1'b0;
    repeat (40) begin
      @(negedge i_clk);
      if (o_gate_sclk && !prev) sh = {sh[14:0], o_gate_sdat};
      prev = o_gate_sclk;
      if (o_gate_sbusy) nbusy++;
    end
    check(sh, 16'h2201);
    check(nbusy[15:0], 16'd32);
    $display("gate link done");
    host_u.wr(8'h03, 8'h01);
    host_u.wr(8'h00, 8'h14);
    @(negedge i_clk);
    check(flags, RST);
    host_u.wr(8'h00, 8'h14);
    @(negedge i_clk);
    check(flags, 14'b00011000000000);
    $display("command reset done");
    host_u.wr(8'h0d, 8'h01);
    foreach (scans[k]) scan_check(scans[k]);
    $display("scan order done");
    give_verdict();
  end
endmodule // tb_lcdctl_regs
